// ===== rtl/cesf_pkg.sv
// constants for the can error status flag block
package cesf_pkg;

    // register indices; byte address is four times the index
    localparam logic [9:0] CESF_IDX_TX_COUNT   = 10'h01c;
    localparam logic [9:0] CESF_IDX_RX_COUNT   = 10'h01d;
    localparam logic [9:0] CESF_IDX_FLAGS      = 10'h02d;
    localparam logic [9:0] CESF_IDX_IRQ_STATUS = 10'h030;
    localparam logic [9:0] CESF_IDX_IRQ_MASK   = 10'h031;

    // apb widths
    localparam int CESF_ADDR_W = 12;
    localparam int CESF_DATA_W = 32;

    // error flag register fields
    localparam int CESF_F_BUF1_OVF  = 7;
    localparam int CESF_F_BUF0_OVF  = 6;
    localparam int CESF_F_BUS_OFF   = 5;
    localparam int CESF_F_TX_PASS   = 4;
    localparam int CESF_F_RX_PASS   = 3;
    localparam int CESF_F_TX_WARN   = 2;
    localparam int CESF_F_RX_WARN   = 1;
    localparam int CESF_F_COMB_WARN = 0;

    // interrupt status and mask fields
    localparam int CESF_I_RX_WARN  = 0;
    localparam int CESF_I_TX_WARN  = 1;
    localparam int CESF_I_RX_PASS  = 2;
    localparam int CESF_I_TX_PASS  = 3;
    localparam int CESF_I_BUS_OFF  = 4;
    localparam int CESF_I_BUF0_OVF = 5;
    localparam int CESF_I_BUF1_OVF = 6;
    localparam int CESF_IRQ_W      = 7;

    // counter thresholds
    localparam logic [7:0] CESF_WARN_LIMIT    = 8'h60;
    localparam logic [7:0] CESF_PASSIVE_LIMIT = 8'h80;
    localparam logic [7:0] CESF_BUS_OFF_LIMIT = 8'hff;

    // reset values
    localparam logic [7:0] CESF_COUNT_RESET = 8'h00;
    localparam logic [7:0] CESF_FLAGS_RESET = 8'h00;
    localparam logic [6:0] CESF_IRQ_RESET   = 7'h00;
    localparam logic [6:0] CESF_MASK_RESET  = 7'h00;

endpackage : cesf_pkg

// ===== rtl/cesf_top.sv
// can error counters, error flag register, apb slave and error interrupt
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - transmit count register, read-only, resets zero
// - receive count register, read-only, resets zero
// - flag register: overflow bits writable, others read-only
// - overflow flags sticky until host clears
// - bus-off sets when transmit count reaches 255
// - bus-off clears only after recovery completes
// - transmit passive while count above 127
// - receive passive while count at least 128
// - transmit warning while count at least 96
// - receive warning while count at least 96
// - combined warning when either count reaches 96
module cesf_top (
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [cesf_pkg::CESF_ADDR_W-1:0] paddr,
    input  wire logic [cesf_pkg::CESF_DATA_W-1:0] pwdata,
    input  wire logic [3:0]                     pstrb,
    output logic      [cesf_pkg::CESF_DATA_W-1:0] prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire logic                           tx_count_load,
    input  wire logic [7:0]                     tx_count_value,
    input  wire logic                           rx_count_load,
    input  wire logic [7:0]                     rx_count_value,
    input  wire logic                           bus_recovery_done,
    input  wire logic                           buffer_zero_accept,
    input  wire logic                           buffer_one_accept,
    input  wire logic                           buffer_zero_full_flag,
    input  wire logic                           buffer_one_full_flag,
    output logic                                bus_off,
    output logic                                error_passive,
    output logic                                irq
);
    import cesf_pkg::*;

    // register state
    logic [7:0]          tx_error_count_q;
    logic [7:0]          tx_error_count_d;
    logic [7:0]          rx_error_count_q;
    logic [7:0]          rx_error_count_d;
    logic                buf1_ovf_q;
    logic                buf0_ovf_q;
    logic                bus_off_flag_q;
    logic                bus_off_flag_d;
    logic                tx_pass_q;
    logic                rx_pass_q;
    logic                tx_warn_q;
    logic                rx_warn_q;
    logic                comb_warn_q;
    logic [6:0]          irq_status_q;
    logic [6:0]          irq_status_d;
    logic [6:0]          irq_mask_q;
    logic [6:0]          irq_mask_d;
    logic [6:0]          irq_events;

    // bus decode
    logic                setup_phase;
    logic                wr_access;
    logic                lane0_wr;
    logic [9:0]          word_idx;
    logic                aligned;
    logic                hit_tx;
    logic                hit_rx;
    logic                hit_flags;
    logic                hit_stat;
    logic                hit_mask;
    logic                mapped;
    logic [7:0]          flags_now;
    logic [7:0]          rd_byte;

    // next flag levels, taken from next counter values
    logic                tx_pass_d;
    logic                rx_pass_d;
    logic                tx_warn_d;
    logic                rx_warn_d;
    logic                comb_warn_d;
    logic                buf0_ovf_set;
    logic                buf1_ovf_set;

    // apb decode; write lands only in the access cycle that has pready high
    assign setup_phase = psel & ~penable;
    assign wr_access   = psel & penable & pready & pwrite;
    assign lane0_wr    = wr_access & pstrb[0];
    assign word_idx    = paddr[CESF_ADDR_W-1:2];
    assign aligned     = (paddr[1:0] == 2'h0);
    assign hit_tx      = aligned & (word_idx == CESF_IDX_TX_COUNT);
    assign hit_rx      = aligned & (word_idx == CESF_IDX_RX_COUNT);
    assign hit_flags   = aligned & (word_idx == CESF_IDX_FLAGS);
    assign hit_stat    = aligned & (word_idx == CESF_IDX_IRQ_STATUS);
    assign hit_mask    = aligned & (word_idx == CESF_IDX_IRQ_MASK);
    assign mapped      = hit_tx | hit_rx | hit_flags | hit_stat | hit_mask;

    // counters follow the protocol engine; the bus cannot alter them
    assign tx_error_count_d = tx_count_load ? tx_count_value
                                            : tx_error_count_q;
    assign rx_error_count_d = rx_count_load ? rx_count_value
                                            : rx_error_count_q;

    // threshold compares on the next counts keep flags and counts in step
    assign tx_pass_d   = (tx_error_count_d >= CESF_PASSIVE_LIMIT);
    assign rx_pass_d   = (rx_error_count_d >= CESF_PASSIVE_LIMIT);
    assign tx_warn_d   = (tx_error_count_d >= CESF_WARN_LIMIT);
    assign rx_warn_d   = (rx_error_count_d >= CESF_WARN_LIMIT);
    assign comb_warn_d = tx_warn_d | rx_warn_d;

    // overflow: a frame accepted while its buffer is still full
    assign buf0_ovf_set = buffer_zero_accept & buffer_zero_full_flag;
    assign buf1_ovf_set = buffer_one_accept & buffer_one_full_flag;

    // bus-off: recovery clears it, yet reaching the limit again wins
    always_comb begin
        bus_off_flag_d = bus_off_flag_q;
        if (bus_recovery_done) begin
            bus_off_flag_d = 1'b0;
        end
        if (tx_error_count_d == CESF_BUS_OFF_LIMIT) begin
            bus_off_flag_d = 1'b1;
        end
    end

    // events that raise the error interrupt: rising levels and overflows
    assign irq_events[CESF_I_RX_WARN]  = rx_warn_d & ~rx_warn_q;
    assign irq_events[CESF_I_TX_WARN]  = tx_warn_d & ~tx_warn_q;
    assign irq_events[CESF_I_RX_PASS]  = rx_pass_d & ~rx_pass_q;
    assign irq_events[CESF_I_TX_PASS]  = tx_pass_d & ~tx_pass_q;
    assign irq_events[CESF_I_BUS_OFF]  = bus_off_flag_d & ~bus_off_flag_q;
    assign irq_events[CESF_I_BUF0_OVF] = buf0_ovf_set;
    assign irq_events[CESF_I_BUF1_OVF] = buf1_ovf_set;

    // status is write-one-to-clear; a new event beats the clear
    always_comb begin
        irq_status_d = irq_status_q;
        if (lane0_wr && hit_stat) begin
            irq_status_d = irq_status_q & ~pwdata[6:0];
        end
        irq_status_d = irq_status_d | irq_events;
    end

    // mask is a plain read/write register
    assign irq_mask_d = (lane0_wr && hit_mask) ? pwdata[6:0] : irq_mask_q;

    // packed view of the error flag register
    always_comb begin
        flags_now                   = CESF_FLAGS_RESET;
        flags_now[CESF_F_BUF1_OVF]  = buf1_ovf_q;
        flags_now[CESF_F_BUF0_OVF]  = buf0_ovf_q;
        flags_now[CESF_F_BUS_OFF]   = bus_off_flag_q;
        flags_now[CESF_F_TX_PASS]   = tx_pass_q;
        flags_now[CESF_F_RX_PASS]   = rx_pass_q;
        flags_now[CESF_F_TX_WARN]   = tx_warn_q;
        flags_now[CESF_F_RX_WARN]   = rx_warn_q;
        flags_now[CESF_F_COMB_WARN] = comb_warn_q;
    end

    // read multiplexer; unmapped addresses read zero
    always_comb begin
        rd_byte = 8'h00;
        if (hit_tx) begin
            rd_byte = tx_error_count_q;
        end else if (hit_rx) begin
            rd_byte = rx_error_count_q;
        end else if (hit_flags) begin
            rd_byte = flags_now;
        end else if (hit_stat) begin
            rd_byte = {1'b0, irq_status_q};
        end else if (hit_mask) begin
            rd_byte = {1'b0, irq_mask_q};
        end
    end

    // no wait state: data is captured in setup, pready high in first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup_phase;
        end
    end

    // read data registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup_phase) begin
            prdata <= pwrite ? '0 : {24'h000000, rd_byte};
        end
    end

    // error answer for addresses outside the map
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            pslverr <= ~mapped;
        end else if (pready) begin
            pslverr <= 1'b0;
        end
    end

    // transmit error counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_error_count_q <= CESF_COUNT_RESET;
        end else begin
            tx_error_count_q <= tx_error_count_d;
        end
    end

    // receive error counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_error_count_q <= CESF_COUNT_RESET;
        end else begin
            rx_error_count_q <= rx_error_count_d;
        end
    end

    // transmit passive flag; read-only, the bus never writes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_pass_q <= 1'b0;
        end else begin
            tx_pass_q <= tx_pass_d;
        end
    end

    // receive passive flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_pass_q <= 1'b0;
        end else begin
            rx_pass_q <= rx_pass_d;
        end
    end

    // transmit warning flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_warn_q <= 1'b0;
        end else begin
            tx_warn_q <= tx_warn_d;
        end
    end

    // receive warning flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_warn_q <= 1'b0;
        end else begin
            rx_warn_q <= rx_warn_d;
        end
    end

    // combined warning; taken from next levels so it never lags them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comb_warn_q <= 1'b0;
        end else begin
            comb_warn_q <= comb_warn_d;
        end
    end

    // bus-off flag as read in the flag register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_off_flag_q <= 1'b0;
        end else begin
            bus_off_flag_q <= bus_off_flag_d;
        end
    end

    // bus-off level for the engine; own copy keeps the pin a flop output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_off <= 1'b0;
        end else begin
            bus_off <= bus_off_flag_d;
        end
    end

    // error-passive level for the protocol engine: either count passive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            error_passive <= 1'b0;
        end else begin
            error_passive <= tx_pass_d | rx_pass_d;
        end
    end

    // buffer zero overflow: host writes it, a new overflow wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf0_ovf_q <= 1'b0;
        end else if (buf0_ovf_set) begin
            buf0_ovf_q <= 1'b1;
        end else if (lane0_wr && hit_flags) begin
            buf0_ovf_q <= pwdata[CESF_F_BUF0_OVF];
        end
    end

    // buffer one overflow: same handling as buffer zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf1_ovf_q <= 1'b0;
        end else if (buf1_ovf_set) begin
            buf1_ovf_q <= 1'b1;
        end else if (lane0_wr && hit_flags) begin
            buf1_ovf_q <= pwdata[CESF_F_BUF1_OVF];
        end
    end

    // interrupt status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_q <= CESF_IRQ_RESET;
        end else begin
            irq_status_q <= irq_status_d;
        end
    end

    // interrupt mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_q <= CESF_MASK_RESET;
        end else begin
            irq_mask_q <= irq_mask_d;
        end
    end

    // interrupt line from next values so it tracks status without lag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_d & irq_mask_d);
        end
    end

endmodule // cesf_top

`default_nettype wire

// ===== tb/cesf_monitor.sv
// port-level assertions for the can error status flag block
`timescale 1ns/10ps
`default_nettype none
module cesf_monitor (
    input wire logic                         pclk,
    input wire logic                         presetn,
    input wire logic                         psel,
    input wire logic                         penable,
    input wire logic                         pwrite,
    input wire logic [cesf_pkg::CESF_ADDR_W-1:0] paddr,
    input wire logic [cesf_pkg::CESF_DATA_W-1:0] prdata,
    input wire logic                         pready,
    input wire logic                         pslverr,
    input wire logic                         tx_count_load,
    input wire logic [7:0]                   tx_count_value,
    input wire logic                         rx_count_load,
    input wire logic [7:0]                   rx_count_value,
    input wire logic                         bus_recovery_done,
    input wire logic                         bus_off,
    input wire logic                         error_passive
);
    import cesf_pkg::*;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    // shadow counts, loaded whole just as the engine loads them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_q <= 8'h00;
            rx_q <= 8'h00;
        end else begin
            if (tx_count_load) tx_q <= tx_count_value;
            if (rx_count_load) rx_q <= rx_count_value;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_read(logic [11:0] a);
        s_setup ##0 (!pwrite && paddr == a);
    endsequence
    sequence s_hit_top;
        tx_count_load && tx_count_value == 8'hff;
    endsequence
    a_ready_access: assert property (s_setup |=> pready)
        else $error("no ready in access cycle");
    a_slverr_unaligned: assert property (s_setup ##0 (paddr[1:0] != 2'h0) |=> pslverr)
        else $error("unaligned access not refused");
    a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_tx_read: assert property (s_read(12'h070) |=> prdata[7:0] == $past(tx_q))
        else $error("transmit count read mismatch");
    a_rx_read: assert property (s_read(12'h074) |=> prdata[7:0] == $past(rx_q))
        else $error("receive count read mismatch");
    a_passive_level: assert property (error_passive == (tx_q >= 8'h80 || rx_q >= 8'h80))
        else $error("passive output disagrees with counts");
    a_bus_off_set: assert property (s_hit_top |=> bus_off)
        else $error("bus-off not set at top count");
    a_bus_off_rise: assert property ($rose(bus_off) |-> $past(tx_count_load))
        else $error("bus-off rose without a count load");
    a_bus_off_hold: assert property (bus_off && !bus_recovery_done |=> bus_off)
        else $error("bus-off cleared without recovery");
endmodule // cesf_monitor
bind cesf_top cesf_monitor i_cesf_monitor (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .tx_count_load, .tx_count_value, .rx_count_load,
    .rx_count_value, .bus_recovery_done, .bus_off, .error_passive);
`default_nettype wire

// ===== tb/test_cesf_top.sv
// self-checking bench for the can error status flag block
`timescale 1ns/10ps
`default_nettype none
module test_cesf_top;
    import cesf_pkg::*;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic [7:0]  tx_count_value = 8'h00, rx_count_value = 8'h00;
    logic [3:0]  pstrb = 4'hf;
    logic        tx_count_load = 1'h0, rx_count_load = 1'h0, bus_recovery_done = 1'h0;
    logic        buffer_zero_accept = 1'h0, buffer_one_accept = 1'h0;
    logic        buffer_zero_full_flag = 1'h0, buffer_one_full_flag = 1'h0;
    logic        pready, pslverr, bus_off, error_passive, irq, rerr;
    int          err_total = 0, total_checks = 0, cyc = 0;
    // boundary pairs around 96 and 128 for both counts
    logic [7:0]  tv [7] = '{8'h5f, 8'h60, 8'h7f, 8'h80, 8'h5f, 8'h00, 8'h00};
    logic [7:0]  rv [7] = '{8'h00, 8'h00, 8'h5f, 8'h60, 8'h80, 8'h7f, 8'h00};
    cesf_top i_cesf_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .tx_count_load, .tx_count_value,
        .rx_count_load, .rx_count_value, .bus_recovery_done, .buffer_zero_accept,
        .buffer_one_accept, .buffer_zero_full_flag, .buffer_one_full_flag, .bus_off,
        .error_passive, .irq);
    always #50 pclk = ~pclk;
    // hang guard, well above the few hundred cycles the run needs
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 4000) begin
            err_total++;
            tally_and_finish;
        end
    end
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask
    // one apb transfer; request held until pready is seen at an edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1);
        rdata = prdata;
        rerr = pslverr;
        chk("access cycles", 32'h1, n);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
        xfer(1'h0, a, 32'h0);
        chk(nm, exp, rdata);
    endtask
    // engine loads both counts in one cycle
    task automatic ld(input logic [7:0] t, input logic [7:0] r);
        @(posedge pclk);
        {tx_count_load, rx_count_load, tx_count_value, rx_count_value} <= {2'h3, t, r};
        @(posedge pclk);
        {tx_count_load, rx_count_load} <= 2'h0;
    endtask
    // pulse {recovery, buffer one accept, buffer zero accept}
    task automatic ev(input logic [2:0] k);
        @(posedge pclk);
        {bus_recovery_done, buffer_one_accept, buffer_zero_accept} <= k;
        @(posedge pclk);
        {bus_recovery_done, buffer_one_accept, buffer_zero_accept} <= 3'h0;
    endtask
    function automatic logic [7:0] flags_of(input logic [7:0] t, input logic [7:0] r);
        return {3'h0, t >= 8'h80, r >= 8'h80, t >= 8'h60, r >= 8'h60, t >= 8'h60 || r >= 8'h60};
    endfunction
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        rd(12'h070, 32'h0, "tx count reset");
        rd(12'h074, 32'h0, "rx count reset");
        rd(12'h0b4, 32'h0, "flags reset");
        xfer(1'h0, 12'h100, 32'h0);
        chk("unmapped slverr", 32'h1, {31'h0, rerr});
        for (int i = 0; i < 7; i++) begin
            ld(tv[i], rv[i]);
            rd(12'h070, {24'h0, tv[i]}, "tx count");
            rd(12'h074, {24'h0, rv[i]}, "rx count");
            rd(12'h0b4, {24'h0, flags_of(tv[i], rv[i])}, "flags");
        end
        // read-only places must shrug off writes
        ld(8'h70, 8'h61);
        xfer(1'h1, 12'h070, 32'hff);
        xfer(1'h1, 12'h074, 32'h00);
        xfer(1'h1, 12'h0b4, 32'h3f);
        rd(12'h070, 32'h70, "tx after write");
        rd(12'h074, 32'h61, "rx after write");
        rd(12'h0b4, 32'h07, "flags after write");
        xfer(1'h1, 12'h0b4, 32'hc0);
        rd(12'h0b4, 32'hc7, "overflow writable");
        xfer(1'h1, 12'h0b4, 32'h00);
        rd(12'h0b4, 32'h07, "overflow cleared");
        // accept while full overflows; accept while empty does not
        buffer_zero_full_flag <= 1'h1;
        ev(3'h3);
        rd(12'h0b4, 32'h47, "buffer zero overflow");
        buffer_one_full_flag <= 1'h1;
        ev(3'h2);
        repeat (5) @(posedge pclk);
        rd(12'h0b4, 32'hc7, "overflow sticky");
        xfer(1'h1, 12'h0b4, 32'h00);
        rd(12'h0b4, 32'h07, "overflow host clear");
        ld(8'hff, 8'h00);
        rd(12'h0b4, 32'h35, "bus off set");
        ld(8'h00, 8'h00);
        rd(12'h0b4, 32'h20, "bus off held");
        chk("bus_off pin", 32'h1, {31'h0, bus_off});
        ev(3'h4);
        rd(12'h0b4, 32'h00, "bus off recovered");
        // interrupt: clear, unmask, raise, mask, clear
        xfer(1'h1, 12'h0c0, 32'h7f);
        rd(12'h0c0, 32'h00, "irq status cleared");
        xfer(1'h1, 12'h0c4, 32'h02);
        ld(8'h60, 8'h00);
        rd(12'h0c0, 32'h02, "irq status tx warn");
        chk("irq raised", 32'h1, {31'h0, irq});
        xfer(1'h1, 12'h0c4, 32'h00);
        rd(12'h0c4, 32'h00, "irq mask");
        chk("irq masked", 32'h0, {31'h0, irq});
        xfer(1'h1, 12'h0c0, 32'h02);
        rd(12'h0c0, 32'h00, "irq status w1c");
        // a write with lane zero off must leave the mask alone
        pstrb <= 4'he;
        xfer(1'h1, 12'h0c4, 32'h7f);
        pstrb <= 4'hf;
        rd(12'h0c4, 32'h00, "mask strobe off");
        // mid-run reset returns both counts, the flag register and the passive pin to zero
        ld(8'h90, 8'h85);
        @(posedge pclk);
        chk("passive pin", 32'h1, {31'h0, error_passive});
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        chk("passive pin reset", 32'h0, {31'h0, error_passive});
        rd(12'h070, 32'h0, "tx count rerun");
        rd(12'h074, 32'h0, "rx count rerun");
        rd(12'h0b4, 32'h0, "flags rerun");
        tally_and_finish;
    end
endmodule // test_cesf_top
`default_nettype wire
